// File: logic/qchc_channel.sv
// One counter channel with host byte access, flags and match logic
`timescale 1ns/1ps
module qchc_channel (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       cs,
  input  wire logic       addr,
  input  wire logic       wr,
  input  wire logic       rd,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata,
  output logic            rvalid,
  input  wire logic       ext_snap,
  input  wire logic       ext_load,
  input  wire logic       cnt_up,
  input  wire logic       cnt_dn,
  output logic            irq,
  output logic            cmd_busy,
  output logic      [23:0] count
);
  import qchc_pkg::*;

  qchc_seq_if sq ();
  qchc_byte_seq u_seq (
    .clk_sys (clk_sys),
    .rst     (rst),
    .sq      (sq)
  );

  logic [23:0] cnt_reg;
  logic [23:0] snap_reg;
  logic [23:0] match_reg;
  logic [4:0]  flag_reg;
  logic [5:0]  in_setup_reg;
  logic [5:0]  out_setup_reg;
  logic [1:0]  quad_reg;
  logic        ptr_hold_reg;
  logic        dir_reg;
  logic [7:0]  rdata_reg;
  logic        rvalid_reg;
  logic        irq_reg;
  logic [23:0] cnt_next;
  logic        under_ev;
  logic        over_ev;
  logic        match_ev;
  logic        data_wr;
  logic        data_rd;
  logic        cmd_wr;
  logic [5:0]  cmd;
  logic        master;
  logic        cnt_clear;
  logic        step_en;
  logic        step_dn;

  // Decode of byte-wide host cycles
  assign data_wr = cs && wr && addr == ADDR_DATA;
  assign data_rd = cs && rd && addr == ADDR_DATA;
  assign cmd_wr  = cs && wr && addr == ADDR_CTRL
                   && wdata[7:6] == SEL_CMD;
  assign cmd     = cmd_wr ? wdata[5:0] : 6'h00;
  assign master  = cmd[CMD_MASTER];
  assign cnt_clear = master || cmd[CMD_CNT_RST];

  // Byte pointer control
  assign sq.restart = cmd[CMD_PTR_RST] || master;
  assign sq.step    = (data_wr || data_rd) && !sq.restart;

  // Counter stepping
  assign step_en = in_setup_reg[IN_CNT_EN] && (cnt_up ^ cnt_dn);
  assign step_dn = cnt_dn;
  assign under_ev = step_en && step_dn && cnt_reg == CNT_RST;
  assign over_ev  = step_en && !step_dn && cnt_reg == MATCH_RST;

  always_comb begin
    cnt_next = cnt_reg;
    if (step_en) begin
      cnt_next = step_dn ? cnt_reg - 24'h000001 : cnt_reg + 24'h000001;
    end
  end

  // Match when the counter arrives at the preset value
  assign match_ev = step_en && cnt_next == match_reg;

  // Counter register
  always_ff @(posedge clk_sys) begin
    if (rst || cnt_clear) begin
      cnt_reg <= CNT_RST;
    end else if (cmd[CMD_LOAD] || ext_load) begin
      cnt_reg <= match_reg;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // Snapshot latch, single-edge capture of the whole word
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      snap_reg <= CNT_RST;
    end else if (cmd[CMD_SNAP] || ext_snap) begin
      snap_reg <= cnt_reg;
    end
  end

  // Preset and match register
  always_ff @(posedge clk_sys) begin
    if (rst || master) begin
      match_reg <= MATCH_RST;
    end else if (data_wr && !sq.restart) begin
      case (sq.ptr)
        2'h0:    match_reg[7:0]   <= wdata;
        2'h1:    match_reg[15:8]  <= wdata;
        2'h2:    match_reg[23:16] <= wdata;
        default: match_reg        <= match_reg;
      endcase
    end
  end

  // Setup registers behind the other selector values
  always_ff @(posedge clk_sys) begin
    if (rst || master) begin
      in_setup_reg  <= SETUP_RST;
      out_setup_reg <= SETUP_RST;
      quad_reg      <= QUAD_OFF;
    end else if (cs && wr && addr == ADDR_CTRL) begin
      case (wdata[7:6])
        SEL_INPUT:  in_setup_reg  <= wdata[5:0];
        SEL_OUTPUT: out_setup_reg <= wdata[5:0];
        SEL_QUAD:   quad_reg      <= wdata[1:0];
        default:    quad_reg      <= quad_reg;
      endcase
    end
  end

  // Toggle flags plus sign and direction flags; events win over a clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flag_reg <= 5'h18;
    end else begin
      if (under_ev) begin
        flag_reg[FLG_UNDER] <= cnt_clear ? 1'b1 : !flag_reg[FLG_UNDER];
      end else if (cnt_clear) begin
        flag_reg[FLG_UNDER] <= 1'b0;
      end
      if (over_ev) begin
        flag_reg[FLG_OVER] <= cnt_clear ? 1'b1 : !flag_reg[FLG_OVER];
      end else if (cnt_clear) begin
        flag_reg[FLG_OVER] <= 1'b0;
      end
      if (match_ev) begin
        flag_reg[FLG_MATCH] <= (master || cmd[CMD_MATCH_CLR])
                               ? 1'b1 : !flag_reg[FLG_MATCH];
      end else if (master || cmd[CMD_MATCH_CLR]) begin
        flag_reg[FLG_MATCH] <= 1'b0;
      end
      if (under_ev) begin
        flag_reg[FLG_SIGN] <= 1'b0;
      end else if (over_ev || cnt_clear) begin
        flag_reg[FLG_SIGN] <= 1'b1;
      end
      flag_reg[FLG_DIR] <= 1'b1;
      if (quad_reg != QUAD_OFF) begin
        flag_reg[FLG_DIR] <= step_en ? !step_dn : dir_reg;
      end
    end
  end

  // Last counting direction in quadrature mode
  always_ff @(posedge clk_sys) begin
    if (rst || master) begin
      dir_reg <= 1'b1;
    end else if (step_en) begin
      dir_reg <= !step_dn;
    end
  end

  // Interrupt follows the selected toggle event, never overflow
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else begin
      case (out_setup_reg[IRQ_SEL_LO +: 2])
        IRQ_ON_UNDER: irq_reg <= under_ev;
        IRQ_ON_MATCH: irq_reg <= match_ev;
        default:      irq_reg <= 1'b0;
      endcase
    end
  end

  // Pointer-restart command stays busy until three bytes move
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ptr_hold_reg <= 1'b0;
    end else if (sq.restart) begin
      ptr_hold_reg <= cmd[CMD_PTR_RST];
    end else if (sq.done) begin
      ptr_hold_reg <= 1'b0;
    end
  end

  // Read data: latch bytes by pointer, flags at control address
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_reg  <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= cs && rd;
      if (data_rd) begin
        case (sq.ptr)
          2'h0:    rdata_reg <= snap_reg[7:0];
          2'h1:    rdata_reg <= snap_reg[15:8];
          2'h2:    rdata_reg <= snap_reg[23:16];
          default: rdata_reg <= 8'h00;
        endcase
      end else if (cs && rd) begin
        rdata_reg <= {FLG_UPPER, flag_reg};
      end
    end
  end

  assign rdata    = rdata_reg;
  assign rvalid   = rvalid_reg;
  assign irq      = irq_reg;
  assign cmd_busy = ptr_hold_reg;
  assign count    = cnt_reg;
endmodule : qchc_channel

// File: inc/qchc_pkg.sv
// Package of constants for the quadrature counter host access block
package qchc_pkg;
  localparam int          CNT_W          = 24;
  localparam int          BYTE_W         = 8;
  localparam int          NUM_BYTES      = 3;
  localparam logic [1:0]  PTR_LAST       = 2'h2;
  // Register select: address bit 0 picks data port or control/status port
  localparam logic        ADDR_DATA      = 1'h0;
  localparam logic        ADDR_CTRL      = 1'h1;
  // Write selector in D7..D6 at the control address
  localparam logic [1:0]  SEL_CMD        = 2'h0;
  localparam logic [1:0]  SEL_INPUT      = 2'h1;
  localparam logic [1:0]  SEL_OUTPUT     = 2'h2;
  localparam logic [1:0]  SEL_QUAD       = 2'h3;
  // Command bit positions
  localparam int          CMD_PTR_RST    = 0;
  localparam int          CMD_SNAP       = 1;
  localparam int          CMD_CNT_RST    = 2;
  localparam int          CMD_LOAD       = 3;
  localparam int          CMD_MATCH_CLR  = 4;
  localparam int          CMD_MASTER     = 5;
  // Flag bit positions
  localparam int          FLG_UNDER      = 0;
  localparam int          FLG_OVER       = 1;
  localparam int          FLG_MATCH      = 2;
  localparam int          FLG_SIGN       = 3;
  localparam int          FLG_DIR        = 4;
  localparam logic [2:0]  FLG_UPPER      = 3'h7;
  // Interrupt source selection in output setup bits 5..4
  localparam logic [1:0]  IRQ_ON_UNDER   = 2'h1;
  localparam logic [1:0]  IRQ_ON_MATCH   = 2'h3;
  localparam int          IRQ_SEL_LO     = 4;
  // Input setup bit for counting enable
  localparam int          IN_CNT_EN      = 3;
  // Reset values
  localparam logic [23:0] MATCH_RST      = 24'hFFFFFF;
  localparam logic [23:0] CNT_RST        = 24'h000000;
  localparam logic [5:0]  SETUP_RST      = 6'h00;
  localparam logic [1:0]  QUAD_OFF       = 2'h0;
endpackage : qchc_pkg

// File: inc/qchc_seq_if.sv
// Interface carrying byte pointer control between the channel and sequencer
`timescale 1ns/1ps
interface qchc_seq_if;
  logic       restart;
  logic       step;
  logic [1:0] ptr;
  logic       done;
  modport ctrl (output restart, output step, input ptr, input done);
  modport seq  (input restart, input step, output ptr, output done);
endinterface : qchc_seq_if

// File: logic/qchc_byte_seq.sv
// Two-bit byte sequence pointer for three-byte transfers
`timescale 1ns/1ps
module qchc_byte_seq (
  input wire logic clk_sys,
  input wire logic rst,
  qchc_seq_if.seq  sq
);
  import qchc_pkg::*;
  logic [1:0] ptr_reg;

  // Restart wins over step; advance low, middle, high, then to 3 and hold there
  always_ff @(posedge clk_sys) begin
    if (rst || sq.restart) begin
      ptr_reg <= 2'h0;
    end else if (sq.step && ptr_reg != 2'h3) begin
      ptr_reg <= ptr_reg + 2'h1;
    end
  end

  assign sq.ptr  = ptr_reg;
  assign sq.done = sq.step && ptr_reg == PTR_LAST;
endmodule : qchc_byte_seq

// File: verif/qchc_checker.sv
// Port timing checker for the channel host access block
`timescale 1ns/1ps
module qchc_checker (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        cs,
  input wire logic        addr,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [7:0]  wdata,
  input wire logic        rvalid,
  input wire logic        cnt_up,
  input wire logic        cnt_dn,
  input wire logic        irq,
  input wire logic        cmd_busy,
  input wire logic [23:0] count
);
  logic cw;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  assign cw = cs & wr & addr & (wdata[7:6] == 2'h0);
  a_rvalid_follows: assert property (cs & rd |=> rvalid)
    else $error("no rvalid");
  a_rvalid_cause: assert property (rvalid |-> $past(cs & rd))
    else $error("stray rvalid");
  a_busy_set: assert property (cw & wdata[0] & ~wdata[5] |=> cmd_busy)
    else $error("busy not set");
  a_busy_hold: assert property (cmd_busy & ~cs |=> cmd_busy)
    else $error("busy dropped");
  a_cnt_clear: assert property (
    cw & wdata[2] & ~wdata[3] & (cnt_up == cnt_dn) |=> count == 24'h000000)
    else $error("count not cleared");
  a_master_clr: assert property (
    cw & (wdata[5:0] == 6'h20) |=> (count == 24'h000000) & ~cmd_busy)
    else $error("master reset incomplete");
  a_irq_single: assert property (irq |=> ~irq) else $error("irq long");
  a_no_carry_irq: assert property (
    ($past(count) == 24'hFFFFFF) & (count == 24'h000000) |-> ~irq)
    else $error("irq on overflow");
endmodule : qchc_checker

bind qchc_channel qchc_checker u_chk (.*);

// File: verif/qchc_host.sv
// Host processor model issuing single byte cycles on the channel bus
`timescale 1ns/1ps
module qchc_host (
  input wire logic       clk_sys,
  input wire logic [7:0] rdata,
  input wire logic       rvalid,
  output logic           cs,
  output logic           addr,
  output logic           wr,
  output logic           rd,
  output logic     [7:0] wdata
);
  initial {cs, addr, wr, rd, wdata} = 12'h000;
  task automatic wr_b(input logic a, input logic [7:0] d);
    @(posedge clk_sys) {cs, wr, addr, wdata} <= {2'b11, a, d};
    @(posedge clk_sys) {cs, wr, wdata} <= {2'b00, ~d};
  endtask : wr_b
  task automatic rd_b(input logic a, output logic [7:0] d);
    @(posedge clk_sys) {cs, rd, addr} <= {2'b11, a};
    @(posedge clk_sys) {cs, rd} <= 2'b00;
    #1 d = rvalid ? rdata : 8'hXX;
  endtask : rd_b
endmodule : qchc_host

// File: verif/tb.sv
// Testbench running host byte sequences against one counter channel
`timescale 1ns/1ps
module tb;
  logic        clk_sys, rst, ext_snap, ext_load, cnt_up, cnt_dn, cs, addr;
  logic        wr, rd, rvalid, irq, cmd_busy;
  logic [7:0]  wdata, rdata, b;
  logic [23:0] count;
  int          failures = 0, compares = 0, irqs = 0, cycles = 0;
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  qchc_channel dut (.*);
  qchc_host host (.*);
  task automatic end_of_test(input bit hung);
    failures += hung;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    irqs <= irqs + int'(irq === 1'b1);
    if (cycles == 2000)
      end_of_test(1'b1);
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cmd(input logic [7:0] d);
    host.wr_b(1'b1, d);
    @(posedge clk_sys) #1;
  endtask : cmd
  task automatic fl(input logic [7:0] e);
    host.rd_b(1'b1, b);
    chk({16'h0000, b}, {16'h0000, e});
  endtask : fl
  task automatic step(input logic up);
    @(posedge clk_sys) {cnt_up, cnt_dn} <= {up, ~up};
    @(posedge clk_sys) {cnt_up, cnt_dn} <= 2'b00;
  endtask : step
  task automatic wr_pre(input logic [23:0] v);
    cmd(8'h01);
    for (int i = 0; i < 3; i++)
      host.wr_b(1'b0, v[i*8 +: 8]);
  endtask : wr_pre
  task automatic rd_pos(input logic [23:0] e, input logic [7:0] c);
    logic [23:0] v;
    cmd(c);
    chk({23'h0, cmd_busy}, 24'h000001);
    for (int i = 0; i < 3; i++)
      host.rd_b(1'b0, v[i*8 +: 8]);
    chk(v, e);
    chk({23'h0, cmd_busy}, 24'h000000);
  endtask : rd_pos
  initial begin
    {rst, ext_snap, ext_load, cnt_up, cnt_dn} = 5'h10;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    fl(8'hF8);
    cmd(8'h20);
    cmd(8'h08);
    chk(count, 24'hFFFFFF);
    wr_pre(24'h123456);
    cmd(8'h08);
    chk(count, 24'h123456);
    rd_pos(24'h123456, 8'h03);
    cmd(8'h04);
    cmd(8'h48);
    cmd(8'h90);
    step(1'b0);
    fl(8'hF1);
    step(1'b1);
    fl(8'hFB);
    wr_pre(24'h000001);
    cmd(8'hB0);
    step(1'b1);
    fl(8'hFF);
    chk(24'(irqs), 24'h000002);
    cmd(8'h10);
    fl(8'hFB);
    @(posedge clk_sys) ext_snap <= 1'b1;
    @(posedge clk_sys) ext_snap <= 1'b0;
    rd_pos(24'h000001, 8'h01);
    end_of_test(1'b0);
  end
endmodule : tb
